// ---- verilog/assw_pkg.sv ----
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - every 1024 us close bottom sense switch 128 us, evaluate comparator
// - float plus bottom-phase high result moves address state to high
// - repeated bottom high keeps high; high reports address bit one
// - high plus bottom-phase low result (no current) moves to float
// - float persisting 64 ms debounce starts motion to secure position; code does so only from shutdown or ready, not for float since reset
// - top switch also closed every 1024 us; high result gives low
// - switch pin sensed same way; open gives flag 0, closed 1
// - switch flag and position capture only at sense drive pulses
// - position readback returns position with same-pulse switch flag
// - full status contents refreshed from internal state every 512 us
// - power-up done within 10 ms, then shutdown mode, commands run
// - reset values everywhere, some loaded from one-time memory
// - after power-up or supply reset, bridge drive enables are off
// - soft stop decelerates, then copies actual into target position
// - after soft stop accept positioning unless a fault blocks motion
// - thermal shutdown event performs soft stop, then motor shutdown
// - thermal flags clear only below warning with a full status read
// - undervoltage and lost steps flags clear only by full status read
// - top and bottom phases alternate; comparator debounced 32 us
// - top high to low, bottom high to high, low results toward float
package assw_pkg;

  //----------------------------------------------------------
  // timing
  //----------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int T_FRAME_US     = 1024;
  localparam int T_SENSE_US     = 128;
  localparam int T_CMP_DEB_US   = 32;
  localparam int T_REFRESH_US   = 512;
  localparam int T_FLOAT_DEB_MS = 64;
  localparam int T_POWER_UP_MS  = 10;

  localparam int FRAME_CYC     = T_FRAME_US * 1000 / CLK_PERIOD_NS;
  localparam int SENSE_CYC     = T_SENSE_US * 1000 / CLK_PERIOD_NS;
  localparam int CMP_DEB_CYC   =
    (T_CMP_DEB_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC   = T_REFRESH_US * 1000 / CLK_PERIOD_NS;
  localparam int FLOAT_DEB_CYC =
    (T_FLOAT_DEB_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_CYC  = T_POWER_UP_MS * 1000000 / CLK_PERIOD_NS;

  //----------------------------------------------------------
  // register map
  //----------------------------------------------------------
  localparam logic [3:0] ADDR_CMD      = 4'h0;
  localparam logic [3:0] ADDR_TARGET   = 4'h1;
  localparam logic [3:0] ADDR_POSITION = 4'h2;
  localparam logic [3:0] ADDR_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_STATE    = 4'h4;

  localparam int CMD_GOTO_BIT   = 0;
  localparam int CMD_STOP_BIT   = 1;
  localparam int POS_SWITCH_BIT = 16;

  localparam int ST_TW_BIT     = 0;
  localparam int ST_TSD_BIT    = 1;
  localparam int ST_UV_BIT     = 2;
  localparam int ST_LOSS_BIT   = 3;
  localparam int ST_VDD_BIT    = 4;
  localparam int ST_SWITCH_BIT = 5;
  localparam int ST_ADDR_BIT   = 6;
  localparam int ST_FLOAT_BIT  = 7;
  localparam int ST_MOTION_LSB = 8;

  localparam logic [15:0] TARGET_RESET = 16'h0000;

  //----------------------------------------------------------
  // state types
  //----------------------------------------------------------
  typedef enum logic [1:0] {
    ASSW_ADDR_FLOAT = 2'b00,
    ASSW_ADDR_LOW   = 2'b01,
    ASSW_ADDR_HIGH  = 2'b10
  } assw_addr_t;

  typedef enum logic [1:0] {
    ASSW_MOT_SHUTDOWN = 2'b00,
    ASSW_MOT_READY    = 2'b01,
    ASSW_MOT_RUN      = 2'b10,
    ASSW_MOT_STOP     = 2'b11
  } assw_motion_t;

endpackage

// ---- verilog/assw_sense.sv ----
`timescale 1ns/1ns
module assw_sense
  import assw_pkg::*;
#(
  parameter int FRAME_CYCLES     = FRAME_CYC,
  parameter int REFRESH_CYCLES   = REFRESH_CYC,
  parameter int FLOAT_DEB_CYCLES = FLOAT_DEB_CYC,
  parameter int POWER_UP_CYCLES  = POWER_UP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        sense_compare_out,
  input  wire logic        switch_compare_out,
  input  wire logic        thermal_warning_in,
  input  wire logic        thermal_shutdown_in,
  input  wire logic        undervoltage_in,
  input  wire logic        lost_steps_in,
  input  wire logic [15:0] actual_position,
  input  wire logic        motion_stopped,
  input  wire logic [15:0] otp_secure_position,
  output logic             bottom_switch_drive,
  output logic             top_switch_drive,
  output logic             bridge_enable,
  output logic             motion_run,
  output logic             decel_request,
  output logic      [15:0] target_position,
  output logic             hardwired_address_bit,
  output logic             address_float,
  output logic             switch_closed_flag,
  output logic             power_up_done
);

  localparam int HALF_CYCLES = REFRESH_CYCLES;

  //----------------------------------------------------------
  // input synchronisers
  //----------------------------------------------------------
  logic [5:0] sync_a;
  logic [5:0] sync_b;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {lost_steps_in, undervoltage_in, thermal_shutdown_in,
                 thermal_warning_in, switch_compare_out, sense_compare_out};
      sync_b <= sync_a;
    end
  end

  wire tw_level  = sync_b[2];
  wire tsd_level = sync_b[3];
  wire uv_level  = sync_b[4];
  wire sl_level  = sync_b[5];

  //----------------------------------------------------------
  // power-up timer
  //----------------------------------------------------------
  logic [17:0] pu_cnt;
  wire         pu_last = (pu_cnt == 18'(POWER_UP_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pu_cnt        <= 18'h00000;
      power_up_done <= 1'b0;
    end else if (!power_up_done) begin
      pu_cnt        <= pu_cnt + 18'h00001;
      power_up_done <= pu_last;
    end
  end

  // one-time memory content is taken when power-up completes
  logic [15:0] secure_position;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      secure_position <= 16'h0000;
    end else if (!power_up_done && pu_last) begin
      secure_position <= otp_secure_position;
    end
  end

  //----------------------------------------------------------
  // sense frame sequencer
  //----------------------------------------------------------
  logic [14:0] frame_cnt;
  wire         frame_last = (frame_cnt == 15'(FRAME_CYCLES - 1));
  wire         bot_window = (frame_cnt < 15'(SENSE_CYC));
  wire         top_window = (frame_cnt >= 15'(HALF_CYCLES)) &&
                            (frame_cnt < 15'(HALF_CYCLES + SENSE_CYC));
  // evaluation happens in the last cycle the drive flop is high
  wire         bot_eval   = (frame_cnt == 15'(SENSE_CYC));
  wire         top_eval   = (frame_cnt == 15'(HALF_CYCLES + SENSE_CYC));
  wire         refresh    = (frame_cnt == 15'h0000) ||
                            (frame_cnt == 15'(HALF_CYCLES));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_cnt           <= 15'h0000;
      bottom_switch_drive <= 1'b0;
      top_switch_drive    <= 1'b0;
    end else begin
      frame_cnt           <= frame_last ? 15'h0000 : frame_cnt + 15'h0001;
      bottom_switch_drive <= bot_window;
      top_switch_drive    <= top_window;
    end
  end

  //----------------------------------------------------------
  // comparator debounce
  //----------------------------------------------------------
  logic [1:0] cmp_last;
  logic [1:0] cmp_deb;
  logic [9:0] cmp_cnt [2];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_last   <= 2'b00;
      cmp_deb    <= 2'b00;
      cmp_cnt[0] <= 10'h000;
      cmp_cnt[1] <= 10'h000;
    end else begin
      cmp_last <= sync_b[1:0];
      for (int i = 0; i < 2; i++) begin
        if (sync_b[i] != cmp_last[i]) begin
          cmp_cnt[i] <= 10'h000;
        end else if (cmp_cnt[i] == 10'(CMP_DEB_CYC - 1)) begin
          cmp_deb[i] <= cmp_last[i];
        end else begin
          cmp_cnt[i] <= cmp_cnt[i] + 10'h001;
        end
      end
    end
  end

  //----------------------------------------------------------
  // address state machine
  //----------------------------------------------------------
  assw_addr_t addr_state;
  assw_addr_t next_addr_state;

  always_comb begin
    next_addr_state = addr_state;
    case (addr_state)
      ASSW_ADDR_FLOAT: begin
        if (bot_eval && cmp_deb[0]) begin
          next_addr_state = ASSW_ADDR_HIGH;
        end else if (top_eval && cmp_deb[0]) begin
          next_addr_state = ASSW_ADDR_LOW;
        end
      end
      ASSW_ADDR_LOW: begin
        if (bot_eval && cmp_deb[0]) begin
          next_addr_state = ASSW_ADDR_HIGH;
        end else if (top_eval && !cmp_deb[0]) begin
          next_addr_state = ASSW_ADDR_FLOAT;
        end
      end
      ASSW_ADDR_HIGH: begin
        if (top_eval && cmp_deb[0]) begin
          next_addr_state = ASSW_ADDR_LOW;
        end else if (bot_eval && !cmp_deb[0]) begin
          next_addr_state = ASSW_ADDR_FLOAT;
        end
      end
      default: next_addr_state = ASSW_ADDR_FLOAT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addr_state            <= ASSW_ADDR_FLOAT;
      hardwired_address_bit <= 1'b0;
      address_float         <= 1'b1;
    end else begin
      addr_state            <= next_addr_state;
      // high keeps reporting one while bottom results stay high
      hardwired_address_bit <= (next_addr_state == ASSW_ADDR_HIGH);
      address_float         <= (next_addr_state == ASSW_ADDR_FLOAT);
    end
  end

  //----------------------------------------------------------
  // float debounce toward secure position
  //----------------------------------------------------------
  logic [20:0] float_cnt;
  logic        float_done;
  wire         float_fire = (addr_state == ASSW_ADDR_FLOAT) && !float_done
                            && (float_cnt == 21'(FLOAT_DEB_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      float_cnt  <= 21'h000000;
      float_done <= 1'b1;  // reset float was never sensed, no timer
    end else if (addr_state != ASSW_ADDR_FLOAT) begin
      float_cnt  <= 21'h000000;
      float_done <= 1'b0;
    end else if (float_fire) begin
      float_done <= 1'b1;
    end else if (!float_done) begin
      float_cnt  <= float_cnt + 21'h000001;
    end
  end

  //----------------------------------------------------------
  // switch sensing with position capture
  //----------------------------------------------------------
  logic        sw_bot_seen;
  logic        sw_top_seen;
  logic [15:0] captured_position;
  wire         sw_eval   = bot_eval || top_eval;
  wire         sw_closed = bot_eval ? (cmp_deb[1] || sw_top_seen)
                                    : (cmp_deb[1] || sw_bot_seen);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sw_bot_seen        <= 1'b0;
      sw_top_seen        <= 1'b0;
      switch_closed_flag <= 1'b0;
      captured_position  <= 16'h0000;
    end else if (sw_eval) begin
      if (bot_eval) begin
        sw_bot_seen <= cmp_deb[1];
      end else begin
        sw_top_seen <= cmp_deb[1];
      end
      switch_closed_flag <= sw_closed;
      captured_position  <= actual_position;
    end
  end

  //----------------------------------------------------------
  // register decode
  //----------------------------------------------------------
  wire status_read = rd && (addr == ADDR_STATUS);
  wire cmd_write   = wr && (addr == ADDR_CMD);
  wire goto_cmd    = cmd_write && wdata[CMD_GOTO_BIT];
  wire stop_cmd    = cmd_write && wdata[CMD_STOP_BIT];
  wire target_wr   = wr && (addr == ADDR_TARGET);

  //----------------------------------------------------------
  // sticky status flags, set wins over clear
  //----------------------------------------------------------
  logic tw_flag;
  logic tsd_flag;
  logic uv_flag;
  logic loss_flag;
  logic vdd_flag;
  wire  temp_clear = status_read && !tw_level;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tw_flag   <= 1'b0;
      tsd_flag  <= 1'b0;
      uv_flag   <= 1'b0;
      loss_flag <= 1'b0;
      vdd_flag  <= 1'b1;
    end else begin
      tw_flag   <= tw_level  || (tw_flag  && !temp_clear);
      tsd_flag  <= tsd_level || (tsd_flag && !temp_clear);
      uv_flag   <= uv_level  || (uv_flag  && !status_read);
      loss_flag <= sl_level  || (loss_flag && !status_read);
      vdd_flag  <= vdd_flag && !status_read;
    end
  end

  //----------------------------------------------------------
  // motion control
  //----------------------------------------------------------
  assw_motion_t mot_state;
  assw_motion_t next_mot_state;
  logic         tsd_prev;
  logic         stop_to_shutdown;
  wire          tsd_event   = tsd_level && !tsd_prev;
  wire          fault_block = tsd_flag || uv_flag || tsd_level;
  wire          move_req    = (goto_cmd || float_fire) && power_up_done;
  wire          move_ok     = move_req && !fault_block;

  always_comb begin
    next_mot_state = mot_state;
    case (mot_state)
      ASSW_MOT_SHUTDOWN: begin
        if (move_ok) begin
          next_mot_state = ASSW_MOT_RUN;
        end
      end
      ASSW_MOT_READY: begin
        if (tsd_event) begin
          next_mot_state = ASSW_MOT_SHUTDOWN;
        end else if (move_ok) begin
          next_mot_state = ASSW_MOT_RUN;
        end
      end
      ASSW_MOT_RUN: begin
        if (tsd_event || stop_cmd) begin
          next_mot_state = ASSW_MOT_STOP;
        end else if (actual_position == target_position) begin
          next_mot_state = ASSW_MOT_READY;
        end
      end
      ASSW_MOT_STOP: begin
        if (motion_stopped) begin
          next_mot_state = (stop_to_shutdown || tsd_event)
                           ? ASSW_MOT_SHUTDOWN : ASSW_MOT_READY;
        end
      end
      default: next_mot_state = ASSW_MOT_SHUTDOWN;
    endcase
  end

  wire stop_done = (mot_state == ASSW_MOT_STOP) && motion_stopped;
  wire load_move = move_ok && (next_mot_state == ASSW_MOT_RUN) &&
                   (mot_state != ASSW_MOT_RUN);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mot_state        <= ASSW_MOT_SHUTDOWN;
      tsd_prev         <= 1'b0;
      stop_to_shutdown <= 1'b0;
      target_position  <= TARGET_RESET;
      bridge_enable    <= 1'b0;
      motion_run       <= 1'b0;
      decel_request    <= 1'b0;
    end else begin
      mot_state <= next_mot_state;
      tsd_prev  <= tsd_level;
      if (mot_state != ASSW_MOT_STOP) begin
        stop_to_shutdown <= tsd_event;
      end else if (tsd_event) begin
        stop_to_shutdown <= 1'b1;
      end
      if (stop_done) begin
        target_position <= actual_position;
      end else if (float_fire && load_move) begin
        target_position <= secure_position;
      end else if (target_wr) begin
        target_position <= wdata[15:0];
      end
      bridge_enable <= power_up_done &&
                       (next_mot_state != ASSW_MOT_SHUTDOWN);
      motion_run    <= (next_mot_state == ASSW_MOT_RUN);
      decel_request <= (next_mot_state == ASSW_MOT_STOP);
    end
  end

  //----------------------------------------------------------
  // status snapshot
  //----------------------------------------------------------
  logic [31:0] status_snap;
  wire  [31:0] status_live = {22'h000000, mot_state, address_float,
                              hardwired_address_bit, switch_closed_flag,
                              vdd_flag, loss_flag, uv_flag, tsd_flag,
                              tw_flag};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      status_snap <= 32'h00000010;
    end else if (refresh) begin
      status_snap <= status_live;
    end
  end

  //----------------------------------------------------------
  // read data
  //----------------------------------------------------------
  wire [31:0] pos_word = {15'h0000, switch_closed_flag, captured_position};
  wire [31:0] rd_mux =
    (addr == ADDR_TARGET)   ? {16'h0000, target_position} :
    (addr == ADDR_POSITION) ? pos_word :
    (addr == ADDR_STATUS)   ? status_snap :
    (addr == ADDR_STATE)    ? status_live : 32'h00000000;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd ? rd_mux : 32'h00000000;
    end
  end

endmodule // assw_sense

// ---- tb/assw_pin_model.sv ----
`timescale 1ns/1ns
module assw_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       bottom_switch_drive,
  input  wire logic       top_switch_drive,
  input  wire logic [1:0] pin_mode,
  input  wire logic       switch_closed,
  output logic            sense_compare_out,
  output logic            switch_compare_out
);
  // pin_mode: 0 open, 1 pulled_to_ground, 2 pulled_to_battery
  logic idle_pat = 1'b0;

  // no switch closed: comparator output is meaningless, so it toggles
  always_ff @(posedge ref_clk) begin
    idle_pat <= ~idle_pat;
  end

  assign sense_compare_out = bottom_switch_drive ? (pin_mode == 2'h2) :
    top_switch_drive ? (pin_mode == 2'h1) : idle_pat;
  // a closed switch shorts the pin to ground: current only in the top phase
  assign switch_compare_out = top_switch_drive ? switch_closed :
    bottom_switch_drive ? 1'b0 : idle_pat;
endmodule // assw_pin_model

// ---- tb/assw_sense_checker.sv ----
`timescale 1ns/1ns
module assw_sense_checker
  import assw_pkg::*;
#(
  parameter int FRAME_CYCLES    = FRAME_CYC,
  parameter int POWER_UP_CYCLES = POWER_UP_CYC
) (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [15:0] actual_position,
  input wire logic        bottom_switch_drive,
  input wire logic        top_switch_drive,
  input wire logic        bridge_enable,
  input wire logic        motion_run,
  input wire logic        decel_request,
  input wire logic [15:0] target_position,
  input wire logic        hardwired_address_bit,
  input wire logic        address_float,
  input wire logic        switch_closed_flag,
  input wire logic        power_up_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  int unsigned bot_len, since_bot, since_drv, up_cnt;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bot_len   <= 0;
      since_bot <= 0;
      since_drv <= 255;
      up_cnt    <= 0;
    end else begin
      bot_len   <= bottom_switch_drive ? bot_len + 1 : 0;
      since_bot <= $rose(bottom_switch_drive) ? 1 : since_bot + 1;
      since_drv <= (bottom_switch_drive || top_switch_drive) ? 0 :
                   since_drv + (since_drv < 255);
      up_cnt    <= up_cnt + (up_cnt < 1000000);
    end
  end

  sequence s_stop_end;
    decel_request ##1 !decel_request;
  endsequence

  a_bottom_len: assert property (
    $fell(bottom_switch_drive) |-> bot_len == SENSE_CYC)
    else $error("bottom pulse length wrong");
  a_phase_gap: assert property (
    $rose(top_switch_drive) |-> since_bot == FRAME_CYCLES / 2)
    else $error("top phase not half a frame after bottom");
  a_phase_excl: assert property (
    !(bottom_switch_drive && top_switch_drive))
    else $error("both sense switches closed");
  a_sense_sync: assert property (
    $changed(hardwired_address_bit) || $changed(address_float) ||
    $changed(switch_closed_flag) |-> since_drv <= 4)
    else $error("sense result changed away from a drive pulse");
  a_addr_excl: assert property (
    hardwired_address_bit |-> !address_float)
    else $error("address high and float together");
  a_stop_copy: assert property (
    s_stop_end |-> target_position == $past(actual_position))
    else $error("target not loaded after stop");
  a_bridge_off: assert property (
    !power_up_done |-> !bridge_enable && !motion_run)
    else $error("drive active before power-up");
  a_power_time: assert property (
    $rose(power_up_done) |-> up_cnt >= POWER_UP_CYCLES - 1 &&
    up_cnt <= POWER_UP_CYCLES + 1)
    else $error("power-up done at wrong time");
  a_power_late: assert property (
    up_cnt > POWER_UP_CYCLES + 1 |-> power_up_done)
    else $error("power-up not done in time");
  a_read_idle: assert property (
    !$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule // assw_sense_checker

bind assw_sense assw_sense_checker #(
  .FRAME_CYCLES(FRAME_CYCLES), .POWER_UP_CYCLES(POWER_UP_CYCLES)
) u_checker (
  .ref_clk, .resetn, .rd, .rdata, .actual_position, .bottom_switch_drive,
  .top_switch_drive, .bridge_enable, .motion_run, .decel_request,
  .target_position, .hardwired_address_bit, .address_float,
  .switch_closed_flag, .power_up_done
);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top
  import assw_pkg::*;
;
  localparam int F  = 5200;
  localparam int PU = 20;
  logic        ref_clk, resetn, wr, rd, sense_cmp, switch_cmp, stopped;
  logic        tw_in, tsd_in, uv_in, loss_in, sw_closed, bot_drv, top_drv;
  logic        bridge_en, run, decel, hw_bit, addr_float, sw_flag, pu_done;
  logic [1:0]  pin_mode;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic [15:0] act_pos, otp_pos, tgt_pos;
  int          cyc, fail_count, checks_done, base;

  assw_sense #(
    .FRAME_CYCLES(F), .REFRESH_CYCLES(F / 2),
    .FLOAT_DEB_CYCLES(200), .POWER_UP_CYCLES(PU)
  ) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sense_compare_out(sense_cmp),
    .switch_compare_out(switch_cmp), .thermal_warning_in(tw_in),
    .thermal_shutdown_in(tsd_in), .undervoltage_in(uv_in),
    .lost_steps_in(loss_in), .actual_position(act_pos),
    .motion_stopped(stopped), .otp_secure_position(otp_pos),
    .bottom_switch_drive(bot_drv), .top_switch_drive(top_drv),
    .bridge_enable(bridge_en), .motion_run(run), .decel_request(decel),
    .target_position(tgt_pos), .hardwired_address_bit(hw_bit),
    .address_float(addr_float), .switch_closed_flag(sw_flag),
    .power_up_done(pu_done)
  );

  assw_pin_model u_pins (
    .ref_clk(ref_clk), .bottom_switch_drive(bot_drv),
    .top_switch_drive(top_drv), .pin_mode(pin_mode),
    .switch_closed(sw_closed), .sense_compare_out(sense_cmp),
    .switch_compare_out(switch_cmp)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= resetn ? cyc + 1 : 0;

  //------------------------------------------------------------
  // access tasks
  //------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic at(input int c);
    int n;
    n = 0;
    while (cyc < c && n < 12000) begin
      @(negedge ref_clk);
      n++;
    end
    if (cyc < c) begin
      fail_count++;
      $display("MISMATCH at %0t: wait for cycle %0d timed out", $time, c);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    check(rdata & m, exp);
  endtask

  task automatic results();
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    $display("MISMATCH at %0t: run timed out", $time);
    results();
  end

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    {resetn, wr, rd, tw_in, tsd_in, uv_in, loss_in} = 7'h00;
    {stopped, sw_closed} = 2'h0;
    addr = 4'h0;
    wdata = 32'h0;
    pin_mode = 2'h2;
    act_pos = 16'h0000;
    otp_pos = 16'h1234;
    repeat (11) @(posedge ref_clk);
    @(negedge ref_clk);
    check({29'h0, bridge_en, addr_float, hw_bit}, 32'h2);
    @(posedge ref_clk);
    resetn <= 1'b1;
    wr_reg(ADDR_TARGET, 32'h55);
    wr_reg(ADDR_CMD, 32'h1);
    idle(2);
    check({31'h0, run}, 32'h0);
    rd_chk(ADDR_STATE, 32'hFFFF_FFFF, 32'h90);
    rd_chk(ADDR_STATUS, 32'h7F, 32'h10);
    rd_chk(4'hF, 32'hFFFF_FFFF, 32'h0);
    at(PU - 1);
    check({31'h0, pu_done}, 32'h0);
    at(PU);
    check({31'h0, pu_done}, 32'h1);
    at(2600);
    check({30'h0, hw_bit, addr_float}, 32'h2);
    at(F + 2600);
    check({30'h0, hw_bit, addr_float}, 32'h2);
    @(posedge ref_clk);
    pin_mode <= 2'h0;
    at(F + 5180);
    check({30'h0, hw_bit, addr_float}, 32'h2);
    at(2 * F + 2600);
    check({29'h0, hw_bit, addr_float, run}, 32'h2);
    at(2 * F + 2800);
    check({15'h0, run, tgt_pos}, 32'h1_1234);
    wr_reg(ADDR_CMD, 32'h2);
    idle(2);
    check({30'h0, run, decel}, 32'h1);
    @(posedge ref_clk);
    act_pos <= 16'h0400;
    stopped <= 1'b1;
    idle(3);
    check({14'h0, run, decel, tgt_pos}, 32'h0400);
    @(posedge ref_clk);
    stopped <= 1'b0;
    wr_reg(ADDR_TARGET, 32'h10);
    wr_reg(ADDR_CMD, 32'h1);
    idle(2);
    check({30'h0, bridge_en, run}, 32'h3);
    rd_chk(ADDR_TARGET, 32'hFFFF, 32'h10);
    @(posedge ref_clk);
    tsd_in <= 1'b1;
    tw_in  <= 1'b1;
    idle(6);
    check({30'h0, run, decel}, 32'h1);
    @(posedge ref_clk);
    stopped <= 1'b1;
    idle(3);
    rd_chk(ADDR_STATE, 32'h303, 32'h3);
    @(posedge ref_clk);
    stopped <= 1'b0;
    wr_reg(ADDR_CMD, 32'h1);
    idle(2);
    check({31'h0, run}, 32'h0);
    idle(F / 2 + 10);
    rd_chk(ADDR_STATUS, 32'h3, 32'h3);
    rd_chk(ADDR_STATE, 32'h3, 32'h3);
    @(posedge ref_clk);
    tsd_in <= 1'b0;
    tw_in  <= 1'b0;
    idle(6);
    rd_chk(ADDR_STATE, 32'h3, 32'h3);
    rd_chk(ADDR_STATUS, 32'h0, 32'h0);
    rd_chk(ADDR_STATE, 32'h3, 32'h0);
    @(posedge ref_clk);
    uv_in   <= 1'b1;
    loss_in <= 1'b1;
    idle(6);
    @(posedge ref_clk);
    uv_in   <= 1'b0;
    loss_in <= 1'b0;
    idle(6);
    rd_chk(ADDR_STATE, 32'hC, 32'hC);
    rd_chk(ADDR_STATUS, 32'h0, 32'h0);
    rd_chk(ADDR_STATE, 32'hC, 32'h0);
    @(posedge ref_clk);
    pin_mode  <= 2'h1;
    sw_closed <= 1'b1;
    act_pos   <= 16'h0ABC;
    base = (cyc / F + 1) * F;
    at(base + 5180);
    check({29'h0, hw_bit, addr_float, sw_flag}, 32'h1);
    rd_chk(ADDR_POSITION, 32'h1_FFFF, 32'h1_0ABC);
    @(posedge ref_clk);
    act_pos   <= 16'h0BBB;
    sw_closed <= 1'b0;
    rd_chk(ADDR_POSITION, 32'h1_FFFF, 32'h1_0ABC);
    at(base + F + 5180);
    check({31'h0, sw_flag}, 32'h0);
    rd_chk(ADDR_POSITION, 32'h1_FFFF, 32'h0BBB);
    results();
  end
endmodule // tb_top
